// file: rmp_pkg.sv
// Package for the region memory protection checker: map, fields, carriers.
package rmp_pkg;

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int RMP_REGIONS = 8;
  localparam int RMP_IDX_W = 3;
  // Size code n selects a region of 2^(n+1) bytes.
  localparam logic [4:0] RMP_SIZE_MIN = 5'h04;
  localparam logic [4:0] RMP_SIZE_SUB_MIN = 5'h07;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] RMP_OFS_CTRL = 8'h00;
  localparam logic [7:0] RMP_OFS_RSEL = 8'h04;
  localparam logic [7:0] RMP_OFS_RBASE = 8'h08;
  localparam logic [7:0] RMP_OFS_RATTR = 8'h0c;
  localparam logic [7:0] RMP_OFS_FADDR = 8'h10;
  localparam logic [7:0] RMP_OFS_ISTAT = 8'h14;
  localparam logic [7:0] RMP_OFS_ICLR = 8'h18;
  localparam logic [7:0] RMP_OFS_IEN = 8'h1c;

  // ------------------------------------------------------------
  // Reset values and write masks
  // ------------------------------------------------------------
  localparam logic [31:0] RMP_RST_WORD = 32'h0000_0000;
  localparam logic [31:0] RMP_CTRL_WMASK = 32'h0000_0007;
  localparam logic [31:0] RMP_ATTR_WMASK = 32'h1700_ff3f;
  localparam logic [1:0] RMP_INT_MASK = 2'h3;
  // Status bit 0: permission violation, bit 1: no region matched.
  localparam int RMP_INT_PERM = 0;
  localparam int RMP_INT_MISS = 1;

  // ------------------------------------------------------------
  // Read/write permission codes, privileged/user
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    RMP_P_NO_U_NO = 3'h0,
    RMP_P_RW_U_NO = 3'h1,
    RMP_P_RW_U_RO = 3'h2,
    RMP_P_RW_U_RW = 3'h3,
    RMP_P_RO_U_NO = 3'h5,
    RMP_P_RO_U_RO = 3'h6
  } rmp_perm_t;

  // ------------------------------------------------------------
  // Field layouts
  // ------------------------------------------------------------
  typedef struct packed {
    logic [28:0] rsv;
    logic protect_in_fault_handlers;
    logic privileged_background_map;
    logic enable;
  } rmp_ctrl_t;

  typedef struct packed {
    logic [2:0] rsv_a;
    logic execute_forbidden;
    logic rsv_b;
    logic [2:0] perm;
    logic [7:0] rsv_c;
    logic [7:0] subregion_off_bit;
    logic [1:0] rsv_d;
    logic [4:0] size;
    logic region_on;
  } rmp_attr_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic write;
    logic fetch;
    logic priv;
    logic in_fault_handler;
  } rmp_req_t;

  typedef struct packed {
    logic done;
    logic fault;
  } rmp_rsp_t;

endpackage

// file: rmp_checker.sv
// Region memory protection checker with APB register port.
`timescale 1ns/10ps

// Overview of operation
// - Region sizes run as powers of two from 32 bytes to 4 GB by a size code.
// - A fetch that hits a region marked execute forbidden is a violation.
// - Six read/write codes are judged separately for privileged and user access.
// - Each region is split into eight equal sub-regions by the address bits.
// - The sub-region mask acts only on regions of 256 bytes or more.
// - A disabled sub-region does not match its region and leaves a hole.
// - Another enabled region may cover a hole and its attributes then apply.
// - Only regions whose enable flag is set take part in matching.
// - With protection on, a violating access raises a memory management fault.
// - Optionally privileged accesses that match nothing use the default map.
// - Unless set to protect them, fault handler accesses bypass the checker.
// - Disabling a region keeps its base and attributes for later re-enable.
module rmp_checker
  import rmp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core access path
  input rmp_req_t acc_req,
  output rmp_rsp_t acc_rsp,
  output logic mm_fault,
  // Interrupt
  output logic irq
);

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  function automatic logic region_hit(logic [31:0] a, logic [31:0] b,
                                      rmp_attr_t at);
    logic [32:0] span;
    logic [32:0] mask33;
    logic [31:0] sh;
    logic [2:0] sub;
    logic in_range;
    logic holed;
    // Widened so that the 4 GB code does not wrap to a one-byte span.
    span = 33'h1 << (6'(at.size) + 6'h01);
    mask33 = ~(span - 33'h1);
    in_range = ((a ^ b) & mask33[31:0]) == 32'h0000_0000;
    sh = a >> (at.size - 5'h02);
    sub = sh[2:0];
    holed = (at.size >= RMP_SIZE_SUB_MIN) &&
            at.subregion_off_bit[sub];
    region_hit = at.region_on && (at.size >= RMP_SIZE_MIN) &&
                 in_range && !holed;
  endfunction

  function automatic logic perm_ok(logic [2:0] code, logic priv,
                                   logic wr);
    unique case (code)
      RMP_P_NO_U_NO: perm_ok = 1'b0;
      RMP_P_RW_U_NO: perm_ok = priv;
      RMP_P_RW_U_RO: perm_ok = priv | !wr;
      RMP_P_RW_U_RW: perm_ok = 1'b1;
      RMP_P_RO_U_NO: perm_ok = priv & !wr;
      RMP_P_RO_U_RO: perm_ok = !wr;
      default: perm_ok = 1'b0;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  rmp_ctrl_t ctrl_r;
  logic [RMP_IDX_W-1:0] rsel_r;
  logic [31:0] base_r [RMP_REGIONS];
  rmp_attr_t attr_r [RMP_REGIONS];
  logic [31:0] faddr_r;
  logic [1:0] istat_r;
  logic [1:0] ien_r;
  logic [31:0] prdata_r;
  rmp_rsp_t rsp_r;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  wire logic setup_ph = psel && !penable;
  wire logic wr_acc = psel && penable && pwrite;
  wire logic hit_ctrl = paddr == RMP_OFS_CTRL;
  wire logic hit_rsel = paddr == RMP_OFS_RSEL;
  wire logic hit_rbase = paddr == RMP_OFS_RBASE;
  wire logic hit_rattr = paddr == RMP_OFS_RATTR;
  wire logic hit_faddr = paddr == RMP_OFS_FADDR;
  wire logic hit_istat = paddr == RMP_OFS_ISTAT;
  wire logic hit_iclr = paddr == RMP_OFS_ICLR;
  wire logic hit_ien = paddr == RMP_OFS_IEN;
  wire logic mapped = hit_ctrl | hit_rsel | hit_rbase | hit_rattr |
                      hit_faddr | hit_istat | hit_iclr | hit_ien;
  wire logic [1:0] clr_bits = (wr_acc && hit_iclr) ?
                              (pwdata[1:0] & RMP_INT_MASK) : 2'h0;

  wire logic [31:0] rd_mux =
    hit_ctrl ? 32'(ctrl_r) :
    hit_rsel ? {29'h0, rsel_r} :
    hit_rbase ? base_r[rsel_r] :
    hit_rattr ? 32'(attr_r[rsel_r]) :
    hit_faddr ? faddr_r :
    hit_istat ? {30'h0, istat_r} :
    hit_ien ? {30'h0, ien_r} : 32'h0000_0000;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_r;

  // ------------------------------------------------------------
  // Region search
  // ------------------------------------------------------------
  logic any_hit;
  logic [RMP_IDX_W-1:0] win_idx;

  always_comb begin
    any_hit = 1'b0;
    win_idx = '0;
    // Later regions overwrite earlier ones, so the highest number wins.
    for (int i = 0; i < RMP_REGIONS; i++) begin
      if (region_hit(acc_req.addr, base_r[i], attr_r[i])) begin
        any_hit = 1'b1;
        win_idx = RMP_IDX_W'(i);
      end
    end
  end

  wire rmp_attr_t win_attr = attr_r[win_idx];
  wire logic bypass = !ctrl_r.enable ||
                      (acc_req.in_fault_handler &&
                       !ctrl_r.protect_in_fault_handlers);
  wire logic exec_bad = acc_req.fetch && win_attr.execute_forbidden;
  wire logic rw_bad = !perm_ok(win_attr.perm, acc_req.priv,
                               acc_req.write);
  wire logic miss_bad = !(acc_req.priv &&
                          ctrl_r.privileged_background_map);
  wire logic perm_fault = acc_req.valid && !bypass && any_hit &&
                          (exec_bad || rw_bad);
  wire logic miss_fault = acc_req.valid && !bypass && !any_hit &&
                          miss_bad;
  wire logic fault_now = perm_fault || miss_fault;

  assign acc_rsp = rsp_r;
  assign mm_fault = rsp_r.fault;
  assign irq = |(istat_r & ien_r);

  // ------------------------------------------------------------
  // Sequential logic
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_r <= rmp_ctrl_t'(RMP_RST_WORD);
      rsel_r <= '0;
      ien_r <= 2'h0;
      prdata_r <= RMP_RST_WORD;
    end else begin
      if (setup_ph) begin
        prdata_r <= rd_mux;
      end
      if (wr_acc && hit_ctrl) begin
        ctrl_r <= rmp_ctrl_t'(pwdata & RMP_CTRL_WMASK);
      end
      if (wr_acc && hit_rsel) begin
        rsel_r <= pwdata[RMP_IDX_W-1:0];
      end
      if (wr_acc && hit_ien) begin
        ien_r <= pwdata[1:0] & RMP_INT_MASK;
      end
    end
  end

  // Region words change only by their own writes; clearing the on bit
  // leaves base and the other attributes in place.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < RMP_REGIONS; i++) begin
        base_r[i] <= RMP_RST_WORD;
        attr_r[i] <= rmp_attr_t'(RMP_RST_WORD);
      end
    end else begin
      if (wr_acc && hit_rbase) begin
        base_r[rsel_r] <= pwdata;
      end
      if (wr_acc && hit_rattr) begin
        attr_r[rsel_r] <= rmp_attr_t'(pwdata & RMP_ATTR_WMASK);
      end
    end
  end

  // A fault arriving in the cycle of a clear keeps its status bit set.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      istat_r <= 2'h0;
      faddr_r <= RMP_RST_WORD;
      rsp_r <= '0;
    end else begin
      istat_r <= (istat_r & ~clr_bits) | {miss_fault, perm_fault};
      if (fault_now) begin
        faddr_r <= acc_req.addr;
      end
      rsp_r.done <= acc_req.valid;
      rsp_r.fault <= fault_now;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_off_no_fault;
    @(posedge clk) disable iff (reset)
    acc_req.valid && !ctrl_r.enable |=> !mm_fault;
  endproperty
  a_off_no_fault: assert property (p_off_no_fault)
    else $error("fault raised while protection off");

  property p_handler_bypass;
    @(posedge clk) disable iff (reset)
    acc_req.valid && acc_req.in_fault_handler &&
    !ctrl_r.protect_in_fault_handlers |=> !acc_rsp.fault;
  endproperty
  a_handler_bypass: assert property (p_handler_bypass)
    else $error("fault handler access was checked");

  property p_bg_priv;
    @(posedge clk) disable iff (reset)
    acc_req.valid && !bypass && !any_hit && acc_req.priv &&
    ctrl_r.privileged_background_map |=> !mm_fault;
  endproperty
  a_bg_priv: assert property (p_bg_priv)
    else $error("privileged miss faulted with background map");

  property p_user_miss;
    @(posedge clk) disable iff (reset)
    acc_req.valid && !bypass && !any_hit && !acc_req.priv
      |=> mm_fault && istat_r[RMP_INT_MISS];
  endproperty
  a_user_miss: assert property (p_user_miss)
    else $error("unmatched user access did not fault");

  property p_xn;
    @(posedge clk) disable iff (reset)
    acc_req.valid && !bypass && any_hit && acc_req.fetch &&
    win_attr.execute_forbidden |=> mm_fault ##0 istat_r[RMP_INT_PERM];
  endproperty
  a_xn: assert property (p_xn)
    else $error("fetch from execute forbidden region passed");

  property p_perm_none;
    @(posedge clk) disable iff (reset)
    acc_req.valid && !bypass && any_hit &&
    win_attr.perm == RMP_P_NO_U_NO |=> mm_fault;
  endproperty
  a_perm_none: assert property (p_perm_none)
    else $error("no-access region allowed an access");

  property p_hit_enabled;
    @(posedge clk) disable iff (reset)
    any_hit |-> attr_r[win_idx].region_on &&
                region_hit(acc_req.addr, base_r[win_idx], win_attr);
  endproperty
  a_hit_enabled: assert property (p_hit_enabled)
    else $error("winning region is disabled or missed");

  property p_fault_irq;
    @(posedge clk) disable iff (reset)
    fault_now && ien_r == RMP_INT_MASK |=> irq [*2] or
      ($past(fault_now) && clr_bits != 2'h0);
  endproperty
  a_fault_irq: assert property (p_fault_irq)
    else $error("enabled fault did not raise interrupt");

  property p_keep_on_disable;
    @(posedge clk) disable iff (reset)
    wr_acc && hit_rattr && !pwdata[0] |=> $stable(base_r[rsel_r]);
  endproperty
  a_keep_on_disable: assert property (p_keep_on_disable)
    else $error("region base changed by attribute write");

  c_perm_fault: cover property (@(posedge clk) disable iff (reset)
    perm_fault ##1 irq);
  c_overlay: cover property (@(posedge clk) disable iff (reset)
    any_hit && win_idx != '0 && region_hit(acc_req.addr, base_r[0],
    attr_r[0]));
  c_hole: cover property (@(posedge clk) disable iff (reset)
    acc_req.valid && attr_r[0].region_on && !any_hit);

endmodule

// file: rmp_core_model.sv
// Behavioural core model that issues one access per start pulse.
`timescale 1ns/10ps
module rmp_core_model
  import rmp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Command from the bench
  input wire logic start,
  input rmp_req_t cmd,
  // Access path
  output rmp_req_t acc_req
);
  logic [31:0] last_addr_r;
  // Idle fields show the inverse of the last address, never a stale copy.
  assign acc_req = start ? cmd : {1'b0, ~last_addr_r, 4'ha};
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      last_addr_r <= 32'h0000_0000;
    end else if (start) begin
      last_addr_r <= cmd.addr;
    end
  end
endmodule

// file: region_memory_protection_tb.sv
// Self-checking bench for the region memory protection checker.
`timescale 1ns/10ps
module region_memory_protection_tb;
  import rmp_pkg::*;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, mm_fault, irq;
  logic start, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] lf;
  rmp_req_t cmd, acc_req;
  rmp_rsp_t acc_rsp;
  int fails, check_count, ctrl, istat, ien, i, j, faddr;
  int m_base[8], m_attr[8];
  int codes[6] = '{0, 1, 2, 3, 5, 6};

  rmp_checker rmp_checker_i (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .acc_req(acc_req),
    .acc_rsp(acc_rsp), .mm_fault(mm_fault), .irq(irq));
  rmp_core_model rmp_core_model_i (.clk(clk), .reset(reset), .start(start),
    .cmd(cmd), .acc_req(acc_req));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Tasks and reference model
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input string n, input logic [7:0] a,
      input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, e, rd);
  endtask

  function automatic logic [31:0] mk(logic on, logic [4:0] n,
      logic [7:0] s, logic [2:0] pm, logic xn);
    return {3'h0, xn, 1'b0, pm, 8'h00, s, 2'h0, n, on};
  endfunction

  function automatic logic [15:0] lfsr_next(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic set_rgn(input int k, input logic [31:0] b,
      input logic [31:0] at);
    apb(1'b1, RMP_OFS_RSEL, k);
    apb(1'b1, RMP_OFS_RATTR, 32'h0000_0000);
    apb(1'b1, RMP_OFS_RBASE, b);
    apb(1'b1, RMP_OFS_RATTR, at);
    m_base[k] = b;
    m_attr[k] = at & RMP_ATTR_WMASK;
    rdc("rattr", RMP_OFS_RATTR, at & RMP_ATTR_WMASK);
  endtask

  function automatic logic [1:0] expect_f(logic [31:0] a, logic w, f, p, h);
    int hit, n;
    logic [31:0] at;
    logic [2:0] pm;
    logic ok, off;
    hit = -1;
    if (ctrl[0] == 0 || (h && !ctrl[2])) return 2'h0;
    for (int k = 0; k < 8; k++) begin
      at = m_attr[k];
      n = at[5:1];
      off = (n >= 7) ? at[8 + ((a >> (n - 2)) & 7)] : 1'b0;
      if (at[0] && n >= 4 && !off &&
          (a >> (n + 1)) == (m_base[k] >> (n + 1))) hit = k;
    end
    if (hit < 0) return (p && ctrl[1]) ? 2'h0 : 2'h2;
    pm = m_attr[hit][26:24];
    if (p) ok = w ? (pm inside {1, 2, 3}) : (pm inside {1, 2, 3, 5, 6});
    else ok = w ? (pm == 3) : (pm inside {2, 3, 6});
    if (f && m_attr[hit][28]) ok = 1'b0;
    return ok ? 2'h0 : 2'h1;
  endfunction

  task automatic acc(input logic [31:0] a, input logic w, f, p, h);
    logic [1:0] e;
    e = expect_f(a, w, f, p, h);
    @(posedge clk);
    cmd <= {1'b1, a, w, f, p, h};
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    // The verdict stands for one cycle; look at it mid-cycle.
    @(negedge clk);
    istat |= e;
    if (e != 2'h0) faddr = a;
    chk("done", 1'b1, acc_rsp.done);
    chk("fault", e != 0, acc_rsp.fault);
    chk("mm_fault", e != 0, mm_fault);
    chk("irq", (istat & ien) != 0, irq);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, start} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    cmd = '0;
    {fails, check_count, ctrl, istat, ien, faddr} = 0;
    m_base = '{default: 0};
    m_attr = '{default: 0};
    lf = 16'h97f7;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rdc("ctrl", RMP_OFS_CTRL, RMP_RST_WORD);
    rdc("istat", RMP_OFS_ISTAT, RMP_RST_WORD);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("pslverr", 1'b1, er);
    acc(32'h1234_5678, 1'b1, 1'b0, 1'b0, 1'b0);
    $display("test reset and bypass done");
    apb(1'b1, RMP_OFS_IEN, 32'h0000_0003);
    ien = 3;
    for (i = 1; i < 8; i++) begin
      ctrl = i;
      apb(1'b1, RMP_OFS_CTRL, ctrl);
      for (j = 0; j < 4; j++) acc(32'h0000_0040, j[0], 1'b0, j[1], 1'b1);
    end
    rdc("istat", RMP_OFS_ISTAT, istat);
    apb(1'b1, RMP_OFS_ICLR, 32'h0000_0003);
    istat = 0;
    rdc("istat", RMP_OFS_ISTAT, 32'h0000_0000);
    chk("irq", 1'b0, irq);
    ctrl = 1;
    apb(1'b1, RMP_OFS_CTRL, ctrl);
    $display("test control and interrupt done");
    foreach (codes[k]) begin
      set_rgn(0, 32'h0000_1000, mk(1'b1, 5'h0b, 8'h00, codes[k], 1'b1));
      for (j = 0; j < 6; j++) acc(32'h0000_1800, j[0], j[2], j[1], 1'b0);
    end
    for (i = 4; i < 32; i++) begin
      set_rgn(6, 32'h0000_0000, mk(1'b1, i, 8'h00, 3'h3, 1'b0));
      acc(32'((64'h1 << (i + 1)) - 4), 1'b1, 1'b0, 1'b0, 1'b0);
      acc(32'(64'h1 << (i + 1)), 1'b1, 1'b0, 1'b0, 1'b0);
    end
    set_rgn(6, 32'h0000_0000, 32'h0000_0000);
    $display("test permissions and sizes done");
    set_rgn(1, 32'h0000_0100, mk(1'b1, 5'h04, 8'hff, 3'h3, 1'b0));
    acc(32'h0000_0110, 1'b0, 1'b0, 1'b0, 1'b0);
    set_rgn(2, 32'h0000_0200, mk(1'b1, 5'h07, 8'h04, 3'h3, 1'b0));
    for (i = 0; i < 8; i++) acc(32'h0000_0200 + i * 32, 1'b0, 1'b0, 1'b0, 1'b0);
    set_rgn(3, 32'h4000_0000, mk(1'b1, 5'h13, 8'h12, 3'h1, 1'b0));
    set_rgn(4, 32'h4008_0000, mk(1'b1, 5'h10, 8'h00, 3'h3, 1'b0));
    set_rgn(5, 32'h4000_0000, mk(1'b1, 5'h0b, 8'h00, 3'h6, 1'b0));
    acc(32'h4000_0010, 1'b0, 1'b0, 1'b0, 1'b0);
    for (i = 0; i < 40; i++) begin
      lf = lfsr_next(lf);
      acc(32'h4000_0000 | {lf, 4'h0}, lf[0], 1'b0, lf[1], 1'b0);
    end
    $display("test holes and overlap done");
    apb(1'b1, RMP_OFS_RSEL, 32'h0000_0004);
    apb(1'b1, RMP_OFS_RATTR, mk(1'b0, 5'h10, 8'h00, 3'h3, 1'b0));
    m_attr[4] = mk(1'b0, 5'h10, 8'h00, 3'h3, 1'b0);
    acc(32'h4009_0000, 1'b0, 1'b0, 1'b0, 1'b0);
    rdc("rbase", RMP_OFS_RBASE, 32'h4008_0000);
    apb(1'b1, RMP_OFS_RATTR, mk(1'b1, 5'h10, 8'h00, 3'h3, 1'b0));
    m_attr[4] = mk(1'b1, 5'h10, 8'h00, 3'h3, 1'b0);
    acc(32'h4009_0000, 1'b1, 1'b0, 1'b0, 1'b0);
    apb(1'b1, RMP_OFS_IEN, 32'h0000_0001);
    ien = 1;
    rdc("istat", RMP_OFS_ISTAT, istat);
    chk("irq", (istat & ien) != 0, irq);
    rdc("faddr", RMP_OFS_FADDR, faddr);
    $display("test disable and re-enable done");
    report_and_stop;
  end

  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    report_and_stop;
  end
endmodule
